/* verilog/isr_pkg.sv */
// Shared constants, types and helpers for the sensor readout path
package isr_pkg;
  localparam int LANES = 64;
  localparam int COLS_PER_LANE = 128;
  localparam int ROWS = 3072;
  localparam int SPI_BITS = 24;
  localparam logic [6:0] LAST_COL = 7'h7f;
  localparam logic [11:0] LAST_ROW = 12'hbff;
  localparam logic [6:0] DARK_LO_END = 7'h08;
  localparam logic [6:0] DARK_HI_START = 7'h78;
  // Register addresses on the serial port
  localparam logic [6:0] A_ROW_START = 7'h01;
  localparam logic [6:0] A_ROW_END = 7'h02;
  localparam logic [6:0] A_FRAMES = 7'h03;
  localparam logic [6:0] A_EXP1 = 7'h04;
  localparam logic [6:0] A_EXP2 = 7'h05;
  localparam logic [6:0] A_GAIN = 7'h06;
  localparam logic [6:0] A_OFFSET = 7'h07;
  localparam logic [6:0] A_DARK_EN = 7'h08;
  localparam logic [6:0] A_LANE_MODE = 7'h09;
  localparam logic [6:0] A_CTRL = 7'h0a;
  localparam logic [6:0] A_BIT_MODE = 7'h76;
  localparam logic [6:0] A_TEMP = 7'h7f;
  // Values after reset
  localparam logic [15:0] R_ROW_END = 16'h05ff;
  localparam logic [15:0] R_FRAMES = 16'h0001;
  localparam logic [15:0] R_EXP = 16'h0100;
  localparam logic [15:0] R_DARK_EN = 16'h0001;
  // Bit mode codes: 0 is 12 bit, 1 is 10 bit, 2 is 8 bit
  localparam logic [1:0] BM_12 = 2'h0;
  localparam logic [1:0] BM_10 = 2'h1;
  localparam logic [1:0] BM_8 = 2'h2;

  typedef struct packed {
    logic fval;
    logic lval;
    logic dval;
  } isr_ctrl_t;

  typedef struct packed {
    isr_ctrl_t ctrl;
    logic [LANES-1:0][11:0] data;
  } isr_line_t;

  function automatic logic [15:0] isr_reg_reset(input logic [6:0] a);
    unique case (a)
      A_ROW_END: isr_reg_reset = R_ROW_END;
      A_FRAMES: isr_reg_reset = R_FRAMES;
      A_EXP1, A_EXP2: isr_reg_reset = R_EXP;
      A_DARK_EN: isr_reg_reset = R_DARK_EN;
      default: isr_reg_reset = 16'h0000;
    endcase
  endfunction

  // Word width in bits for a bit mode code
  function automatic logic [3:0] isr_width(input logic [1:0] m);
    isr_width = (m == BM_8) ? 4'h8 : ((m == BM_10) ? 4'ha : 4'hc);
  endfunction

  // Keeps the top bits of a left aligned 12-bit word
  function automatic logic [11:0] isr_mask(input logic [1:0] m);
    isr_mask = 12'hfff << (4'hc - isr_width(m));
  endfunction
endpackage

/* verilog/isr_fifo2.sv */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module isr_fifo2 #(
  parameter int W = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  logic [W-1:0] mem_q [0:1];
  logic wr_q;
  logic rd_q;
  logic [1:0] cnt_q;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  // Full and empty straight from the occupancy count
  assign in_ready_o = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o = mem_q[rd_q];

  // Pointers and count
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      wr_q <= wr_q ^ push;
      rd_q <= rd_q ^ pop;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage needs no reset; valid gates its use
  always_ff @(posedge clock_i)
  begin
    if (push)
      mem_q[wr_q] <= in_data_i;
  end
endmodule

/* verilog/isr_readout.sv */
// Sensor readout path: register port, sequencer, pixel processing, lanes
//
// Overview of operation
// - With all lanes active, each lane carries one 128-column group
// - Two rows, top and bottom, per line
// - Rows read in order within programmed window
// - Sixteen dark columns, output switchable by register
// - Words of 8, 10 or 12 bits
// - Programmable digital offset on every converter result
// - Four analog gain settings, x1 to x4
// - 64 data, one control, one clock lane
// - Forwarded DDR clock aligned with data lanes
// - Control lane flags data validity only; frame, line and data flags set together
// - One bit per lane per link edge
// - Temperature reading at register address 127
// - HDR gives odd and even columns own exposures
// - Written registers read back unchanged, except the temperature slot
// - Next exposure runs during previous readout
// - Fewer active lanes, lower frame rate
// - Internal exposure timing or external exposure pin
// - Held frame request starts programmed frame count
// - Serial access: R/W bit, 7 address, 16 data
`timescale 1ns/1ps
module isr_readout (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic lvds_clk_i,
  input wire logic frame_req_i,
  input wire logic texp1_i,
  input wire logic texp2_i,
  input wire logic spi_clk_i,
  input wire logic spi_en_i,
  input wire logic spi_in_i,
  output logic spi_out_o,
  input wire logic [15:0] temp_code_i,
  output logic [11:0] row_top_o,
  output logic [11:0] row_bot_o,
  output logic row_sel_o,
  output logic [6:0] adc_col_o,
  output logic adc_req_o,
  input wire logic adc_valid_i,
  input wire logic [isr_pkg::LANES-1:0][11:0] adc_data_i,
  output logic [1:0] gain_o,
  output logic exp_even_o,
  output logic exp_odd_o,
  output logic [isr_pkg::LANES-1:0] lane_o,
  output logic ctrl_lane_o,
  output logic clk_out_o
);
  typedef enum logic [1:0] {E_IDLE, E_EXP, E_HOLD} isr_exp_t;
  typedef enum logic [1:0] {R_IDLE, R_ROW, R_COL} isr_rd_t;

  // Pin synchronisers: stage 0 is read only by stage 1
  logic [2:0] lk_q, sck_q;
  logic [1:0] sen_q, sin_q, req_q, t1_q, t2_q;
  always_ff @(posedge clock_i)
  begin
    lk_q <= {lk_q[1:0], lvds_clk_i};
    sck_q <= {sck_q[1:0], spi_clk_i};
    sen_q <= {sen_q[0], spi_en_i};
    sin_q <= {sin_q[0], spi_in_i};
    req_q <= {req_q[0], frame_req_i};
    t1_q <= {t1_q[0], texp1_i};
    t2_q <= {t2_q[0], texp2_i};
  end
  wire link_edge = lk_q[2] ^ lk_q[1];
  wire sck_rise = sck_q[1] && !sck_q[2];
  wire sck_fall = !sck_q[1] && sck_q[2];

  // Register file and serial port
  logic [15:0] regs_q [0:127];
  logic [4:0] sbit_q;
  logic [23:0] sin_sh_q;
  logic [15:0] rd_sh_q;
  logic spi_out_q;
  wire s_wr = sin_sh_q[23];
  wire [6:0] s_addr = sin_sh_q[22:16];
  wire commit = sen_q[1] && sck_fall && (sbit_q == 5'd24);
  wire wr_en = commit && s_wr && (s_addr != isr_pkg::A_TEMP);
  wire [6:0] rd_addr = {sin_sh_q[5:0], sin_q[1]}; // Last address bit lands with this edge
  wire [15:0] rd_word = (rd_addr == isr_pkg::A_TEMP) ? temp_code_i : regs_q[rd_addr];
  assign spi_out_o = spi_out_q;

  // Shift in MSB first on rising edges, act on the last falling edge
  always_ff @(posedge clock_i)
  begin
    if (rst_i || !sen_q[1])
    begin
      sbit_q <= 5'd0;
      spi_out_q <= 1'b0;
    end
    else if (sck_rise && sbit_q != 5'd24)
    begin
      sin_sh_q <= {sin_sh_q[22:0], sin_q[1]};
      sbit_q <= sbit_q + 5'd1;
      if (sbit_q == 5'd7 && !sin_sh_q[6])
        rd_sh_q <= rd_word;
    end
    else if (sck_fall)
    begin
      if (sbit_q >= 5'd8 && sbit_q != 5'd24 && !sin_sh_q[sbit_q - 5'd1])
      begin
        spi_out_q <= rd_sh_q[15];
        rd_sh_q <= {rd_sh_q[14:0], 1'b0};
      end
      if (sbit_q == 5'd24)
        sbit_q <= 5'd0; // Back to back accesses with enable held
    end
  end

  // Register storage; temperature slot never stored
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 128; i++)
        regs_q[i] <= isr_pkg::isr_reg_reset(7'(i));
    end
    else if (wr_en)
      regs_q[s_addr] <= sin_sh_q[15:0];
  end

  // Named configuration fields
  wire [11:0] row_start = regs_q[isr_pkg::A_ROW_START][11:0];
  wire [11:0] row_end = regs_q[isr_pkg::A_ROW_END][11:0];
  wire [15:0] frames = regs_q[isr_pkg::A_FRAMES];
  wire [15:0] exp1 = regs_q[isr_pkg::A_EXP1];
  wire [15:0] exp2 = regs_q[isr_pkg::A_EXP2];
  wire [11:0] offset = regs_q[isr_pkg::A_OFFSET][11:0];
  wire dark_en = regs_q[isr_pkg::A_DARK_EN][0];
  wire [1:0] lane_mode = regs_q[isr_pkg::A_LANE_MODE][1:0];
  wire ext_exp = regs_q[isr_pkg::A_CTRL][0];
  wire hdr = regs_q[isr_pkg::A_CTRL][1];
  wire [1:0] bmode = regs_q[isr_pkg::A_BIT_MODE][1:0];
  wire [3:0] width = isr_pkg::isr_width(bmode);
  assign gain_o = regs_q[isr_pkg::A_GAIN][1:0];

  // Frame request: high for 2*width link edges, one hit per pulse
  logic [4:0] req_cnt_q;
  logic req_armed_q;
  logic [15:0] frames_left_q;
  wire req_hit = req_q[1] && req_armed_q && link_edge && (req_cnt_q == {width, 1'b0} - 5'd1);
  always_ff @(posedge clock_i)
  begin
    if (rst_i || !req_q[1])
    begin
      req_cnt_q <= 5'd0;
      req_armed_q <= 1'b1;
    end
    else if (req_hit)
      req_armed_q <= 1'b0;
    else if (link_edge && req_armed_q)
      req_cnt_q <= req_cnt_q + 5'd1;
  end

  // Exposure, independent of readout so the two overlap
  isr_exp_t est_q;
  isr_rd_t rst_q;
  logic [15:0] ecnt_q;
  logic stored_q, seen_q;
  wire [15:0] exp_odd_len = hdr ? exp2 : exp1;
  wire [15:0] exp_long = (exp_odd_len > exp1) ? exp_odd_len : exp1;
  wire ext_odd = hdr ? t2_q[1] : t1_q[1];
  wire exp_done = ext_exp ? (seen_q && !t1_q[1] && !ext_odd) : (ecnt_q >= exp_long);
  wire frame_start = (rst_q == isr_rd_t'(R_IDLE)) && stored_q;
  assign exp_even_o = (est_q == E_EXP) && (ext_exp ? t1_q[1] : (ecnt_q < exp1));
  assign exp_odd_o = (est_q == E_EXP) && (ext_exp ? ext_odd : (ecnt_q < exp_odd_len));
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      est_q <= E_IDLE;
      ecnt_q <= 16'h0000;
      stored_q <= 1'b0;
      seen_q <= 1'b0;
      frames_left_q <= 16'h0000;
    end
    else
    begin
      if (frame_start)
        stored_q <= 1'b0;
      unique case (est_q)
        E_IDLE:
          if (frames_left_q != 16'h0000)
          begin
            est_q <= E_EXP;
            ecnt_q <= 16'h0000;
            seen_q <= 1'b0;
          end
        E_EXP:
        begin
          ecnt_q <= ecnt_q + 16'h0001;
          seen_q <= seen_q || t1_q[1] || ext_odd;
          if (exp_done)
            est_q <= E_HOLD;
        end
        E_HOLD:
          if (!stored_q && !frame_start) // Wait for the pixel store to free up
          begin
            stored_q <= 1'b1;
            frames_left_q <= frames_left_q - 16'h0001;
            est_q <= E_IDLE;
          end
      endcase
      if (req_hit)
        frames_left_q <= frames;
    end
  end

  // Readout sequencer: pairs of rows, columns of each group in order
  logic [11:0] row_q;
  logic [6:0] col_q;
  logic in_ready;
  assign row_top_o = row_q;
  assign row_bot_o = isr_pkg::LAST_ROW - row_q;
  assign row_sel_o = (rst_q == R_ROW);
  assign adc_col_o = col_q;
  assign adc_req_o = (rst_q == R_COL) && in_ready;
  wire take = adc_req_o && adc_valid_i;
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      rst_q <= R_IDLE;
      row_q <= 12'h000;
      col_q <= 7'h00;
    end
    else
      unique case (rst_q)
        R_IDLE:
          if (frame_start)
          begin
            row_q <= row_start;
            rst_q <= R_ROW;
          end
        R_ROW:
        begin
          col_q <= 7'h00;
          rst_q <= R_COL;
        end
        R_COL:
          if (take)
          begin
            col_q <= col_q + 7'h01;
            if (col_q == isr_pkg::LAST_COL)
            begin
              row_q <= row_q + 12'h001;
              rst_q <= (row_q >= row_end) ? R_IDLE : R_ROW;
            end
          end
      endcase
  end

  // Offset, saturation, width mask and dark column blanking
  isr_pkg::isr_line_t in_line, out_line, cur_q;
  logic [12:0] sum [isr_pkg::LANES];
  wire dark_lo = (col_q < isr_pkg::DARK_LO_END);
  wire dark_hi = (col_q >= isr_pkg::DARK_HI_START);
  always_comb
  begin
    in_line.ctrl = '{fval: 1'b1, lval: 1'b1, dval: 1'b1};
    for (int l = 0; l < isr_pkg::LANES; l++)
    begin
      sum[l] = {1'b0, adc_data_i[l]} + {1'b0, offset};
      in_line.data[l] = (sum[l][12] ? 12'hfff : sum[l][11:0]) & isr_pkg::isr_mask(bmode);
    end
    if (!dark_en && dark_lo)
      in_line.data[0] = 12'h000;
    if (!dark_en && dark_hi)
      in_line.data[isr_pkg::LANES-1] = 12'h000;
  end

  // Buffer absorbs serializer stalls; full buffer holds the sequencer
  logic out_valid, out_ready;
  isr_fifo2 #(.W($bits(isr_pkg::isr_line_t))) u_buf (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_valid_i(take),
    .in_ready_o(in_ready),
    .in_data_i(in_line),
    .out_valid_o(out_valid),
    .out_ready_i(out_ready),
    .out_data_o(out_line)
  );

  // Serializer: each link edge sends one bit per lane, MSB first
  logic [3:0] bit_q;
  logic [1:0] pass_q;
  logic clk_out_q;
  logic [11:0] sh_q [isr_pkg::LANES];
  logic [11:0] csh_q;
  wire [6:0] act = 7'd64 >> lane_mode;
  wire [1:0] last_pass = 2'((4'h1 << lane_mode) - 4'h1);
  wire src_ok = (pass_q != 2'h0) || out_valid;
  wire [isr_pkg::LANES-1:0][11:0] src = (pass_q != 2'h0) ? cur_q.data : out_line.data;
  wire isr_pkg::isr_ctrl_t sctl = (pass_q != 2'h0) ? cur_q.ctrl : out_line.ctrl;
  wire load = link_edge && (bit_q == 4'h0);
  assign out_ready = load && (pass_q == 2'h0);
  assign clk_out_o = clk_out_q;
  assign ctrl_lane_o = csh_q[11];
  always_comb
    for (int l = 0; l < isr_pkg::LANES; l++)
      lane_o[l] = sh_q[l][11];

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      bit_q <= 4'h0;
      pass_q <= 2'h0;
      clk_out_q <= 1'b0;
      csh_q <= 12'h000;
      for (int l = 0; l < isr_pkg::LANES; l++)
        sh_q[l] <= 12'h000;
    end
    else if (link_edge)
    begin
      clk_out_q <= ~clk_out_q; // Toggles with every bit
      bit_q <= (bit_q == width - 4'h1) ? 4'h0 : bit_q + 4'h1;
      if (load)
      begin
        if (pass_q == 2'h0 && out_valid)
          cur_q <= out_line;
        if (src_ok)
          pass_q <= (pass_q == last_pass) ? 2'h0 : pass_q + 2'h1;
        csh_q <= src_ok ? {sctl, 9'h000} : 12'h000;
        for (int l = 0; l < isr_pkg::LANES; l++)
          sh_q[l] <= (src_ok && 7'(l) < act) ? src[6'((pass_q << (3'h6 - 3'(lane_mode))) + 6'(l))] : 12'h000;
      end
      else
      begin
        csh_q <= {csh_q[10:0], 1'b0};
        for (int l = 0; l < isr_pkg::LANES; l++)
          sh_q[l] <= {sh_q[l][10:0], 1'b0};
      end
    end
  end

  // Checks on the logic above
  sequence s_commit_wr;
    commit && s_wr && (s_addr != isr_pkg::A_TEMP);
  endsequence
  a_temp_readonly: assert property (@(posedge clock_i) disable iff (rst_i) !(wr_en && s_addr == isr_pkg::A_TEMP)) else $error("temperature slot written");
  a_spi_write_store: assert property (@(posedge clock_i) disable iff (rst_i) s_commit_wr |=> regs_q[$past(s_addr)] == $past(sin_sh_q[15:0])) else $error("register write lost");
  a_frame_req_load: assert property (@(posedge clock_i) disable iff (rst_i) req_hit |=> frames_left_q == $past(frames)) else $error("frame count not loaded");
  a_row_pair: assert property (@(posedge clock_i) disable iff (rst_i) row_sel_o |-> row_top_o + row_bot_o == isr_pkg::LAST_ROW) else $error("row pair mismatch");
  a_row_window: assert property (@(posedge clock_i) disable iff (rst_i) row_sel_o && row_start <= row_end |-> row_top_o >= row_start && row_top_o <= row_end) else $error("row outside window");
  a_clk_follow: assert property (@(posedge clock_i) disable iff (rst_i) link_edge |=> clk_out_o != $past(clk_out_o)) else $error("forwarded clock missed edge");
  a_dark_blank: assert property (@(posedge clock_i) disable iff (rst_i) take && !dark_en && dark_lo |-> in_line.data[0] == 12'h000) else $error("dark column not blanked");
  a_width_mask: assert property (@(posedge clock_i) disable iff (rst_i) take && bmode == isr_pkg::BM_8 |-> in_line.data[1][3:0] == 4'h0) else $error("word wider than mode");
  a_idle_lanes: assert property (@(posedge clock_i) disable iff (rst_i) lane_mode == 2'h1 && $stable(lane_mode) |=> lane_o[63:32] == 32'h0) else $error("inactive lane toggled");
endmodule

/* testbench/isr_adc_model.sv */
// Far-side model: column converter answers and the link clock source
`timescale 1ns/1ps
module isr_adc_model (
  input wire logic clock_i,
  input wire logic adc_req_i,
  input wire logic [6:0] adc_col_i,
  output logic adc_valid_o,
  output logic [isr_pkg::LANES-1:0][11:0] adc_data_o,
  output logic lvds_clk_o
);
  logic taken_q;
  logic slow;
  int wait_n;
  // Free running link clock, phase unrelated to the system clock
  initial
  begin
    lvds_clk_o = 1'b0;
    #7;
    forever #80 lvds_clk_o = ~lvds_clk_o;
  end
  // Note the handshake at the sampling edge
  always @(posedge clock_i) taken_q <= adc_valid_o & adc_req_i;
  // Answers alternate prompt and slow; released data is inverted, never stale
  initial
  begin
    adc_valid_o = 1'b0;
    adc_data_o = '0;
    slow = 1'b0;
    wait_n = 0;
    forever
    begin
      @(negedge clock_i);
      if (taken_q)
      begin
        adc_valid_o = 1'b0;
        adc_data_o = ~adc_data_o;
        slow = ~slow;
        wait_n = slow ? 3 : 0;
      end
      else if (!adc_valid_o && adc_req_i)
      begin
        if (wait_n > 0)
          wait_n--;
        else
        begin
          adc_valid_o = 1'b1;
          for (int l = 0; l < isr_pkg::LANES; l++)
            adc_data_o[l] = {l[4:0], adc_col_i};
        end
      end
    end
  end
endmodule

/* testbench/isr_readout_test.sv */
// Testbench for the readout path: register port, row order and lane words
`timescale 1ns/1ps
module isr_readout_test;
  localparam logic [11:0] OFF = 12'h0f0;
  logic clock_i, rst_i, lvds_clk, frame_req, spi_clk, spi_en, spi_in, spi_out, texp1, texp2;
  logic [11:0] row_top, row_bot;
  logic row_sel, adc_req, adc_valid, exp_even, exp_odd, ctrl_lane, clk_out, co_q;
  logic [6:0] adc_col;
  logic [isr_pkg::LANES-1:0][11:0] adc_data;
  logic [1:0] gain;
  logic [isr_pkg::LANES-1:0] lane;
  logic [11:0] cw, w0, w62, w63;
  logic [15:0] rd;
  int n_mismatch, n_tests, nw, nr, n_even, n_odd, wd, lm;

  isr_readout dut (
    .clock_i(clock_i), .rst_i(rst_i), .lvds_clk_i(lvds_clk), .frame_req_i(frame_req),
    .texp1_i(texp1), .texp2_i(texp2), .spi_clk_i(spi_clk), .spi_en_i(spi_en),
    .spi_in_i(spi_in), .spi_out_o(spi_out), .temp_code_i(16'h1234),
    .row_top_o(row_top), .row_bot_o(row_bot), .row_sel_o(row_sel), .adc_col_o(adc_col),
    .adc_req_o(adc_req), .adc_valid_i(adc_valid), .adc_data_i(adc_data), .gain_o(gain),
    .exp_even_o(exp_even), .exp_odd_o(exp_odd), .lane_o(lane), .ctrl_lane_o(ctrl_lane),
    .clk_out_o(clk_out)
  );
  isr_adc_model far (
    .clock_i(clock_i), .adc_req_i(adc_req), .adc_col_i(adc_col),
    .adc_valid_o(adc_valid), .adc_data_o(adc_data), .lvds_clk_o(lvds_clk)
  );

  // System clock, 20 ns period
  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  // One 24-bit serial access, MSB first; half period of five system clocks
  task automatic spi(input logic [23:0] w, output logic [15:0] r);
    r = '0;
    spi_en = 1'b1;
    for (int i = 23; i >= 0; i--)
    begin
      spi_in = w[i];
      repeat (5) @(negedge clock_i);
      if (i < 16)
        r = {r[14:0], spi_out};
      spi_clk = 1'b1;
      repeat (5) @(negedge clock_i);
      spi_clk = 1'b0;
    end
    repeat (10) @(negedge clock_i);
    spi_en = 1'b0;
    spi_in = 1'b0;
    repeat (10) @(negedge clock_i);
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    spi({1'b1, a, d}, rd);
  endtask

  task automatic rchk(input logic [6:0] a, input logic [15:0] e);
    spi({1'b0, a, 16'h0000}, rd);
    chk16(rd, e);
  endtask

  // Expected lane word: dark columns blanked, offset added and saturated
  function automatic logic [11:0] expw(input int l, input int c);
    logic [12:0] s;
    if ((l == 0 && c < 8) || (l == 63 && c >= 120))
      return 12'h000;
    s = {1'b0, l[4:0], c[6:0]} + {1'b0, OFF};
    return s[12] ? 12'hfff : s[11:0];
  endfunction

  // Expected word on lane l for word n of a frame: group by pass, column, width mask
  function automatic logic [11:0] expl(input int l, input int n);
    int act;
    act = 64 >> lm;
    if (l >= act)
      return 12'h000;
    return expw((n % (1 << lm)) * act + l, (n >> lm) % 128) & (12'hfff << (12 - wd));
  endfunction

  task automatic results;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Deserialise per forwarded clock toggle; a run of three flags marks a data word
  always @(negedge clock_i)
  begin
    if (clk_out !== co_q)
    begin
      co_q = clk_out;
      cw = {cw[10:0], ctrl_lane};
      w0 = {w0[10:0], lane[0]};
      w62 = {w62[10:0], lane[62]};
      w63 = {w63[10:0], lane[63]};
      if (cw[wd-1 -: 3] === 3'b111 && (cw & ~(12'hfff << (wd - 3))) === 12'h000)
      begin
        chk12(12'(w0 << (12 - wd)), expl(0, nw));
        chk12(12'(w62 << (12 - wd)), expl(62, nw));
        chk12(12'(w63 << (12 - wd)), expl(63, nw));
        nw++;
      end
    end
    if (row_sel === 1'b1)
    begin
      chk12(row_top, 12'h002 + 12'(nr % 2));
      chk12(row_bot, 12'hbfd - 12'(nr % 2));
      nr++;
    end
    // Exposure time seen on each column half
    if (exp_even === 1'b1)
      n_even++;
    if (exp_odd === 1'b1)
      n_odd++;
  end

  // Watchdog: both frames together need under a millisecond
  initial
  begin
    #1500000;
    n_mismatch++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end

  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    frame_req = 1'b0;
    spi_clk = 1'b0;
    spi_en = 1'b0;
    spi_in = 1'b0;
    co_q = 1'b0;
    cw = '0;
    n_mismatch = 0;
    n_tests = 0;
    nw = 0;
    nr = 0;
    n_even = 0;
    n_odd = 0;
    wd = 12;
    lm = 0;
    texp1 = 1'b0;
    texp2 = 1'b0;
    repeat (6) @(negedge clock_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clock_i);
    rchk(isr_pkg::A_ROW_END, isr_pkg::R_ROW_END);
    rchk(isr_pkg::A_FRAMES, isr_pkg::R_FRAMES);
    rchk(isr_pkg::A_EXP1, isr_pkg::R_EXP);
    rchk(isr_pkg::A_DARK_EN, isr_pkg::R_DARK_EN);
    wr(isr_pkg::A_ROW_START, 16'h0002);
    wr(isr_pkg::A_ROW_END, 16'h0003);
    wr(isr_pkg::A_EXP1, 16'h0010);
    wr(isr_pkg::A_OFFSET, {4'h0, OFF});
    wr(isr_pkg::A_DARK_EN, 16'h0000);
    rchk(isr_pkg::A_ROW_START, 16'h0002);
    rchk(isr_pkg::A_ROW_END, 16'h0003);
    rchk(isr_pkg::A_OFFSET, {4'h0, OFF});
    rchk(isr_pkg::A_DARK_EN, 16'h0000);
    // Every gain code, ending at unity
    for (int g = 3; g >= 0; g--)
    begin
      wr(isr_pkg::A_GAIN, 16'(g));
      chk16({14'h0000, gain}, 16'(g));
    end
    wr(isr_pkg::A_TEMP, 16'habcd);
    rchk(isr_pkg::A_TEMP, 16'h1234);
    // Request held well past 24 link edges
    frame_req = 1'b1;
    repeat (125) @(negedge clock_i);
    frame_req = 1'b0;
    for (int i = 0; i < 20000 && nw < 256; i++)
      @(negedge clock_i);
    repeat (2000) @(negedge clock_i);
    chk16(16'(nw), 16'h0100);
    chk16(16'(nr), 16'h0002);
    // Second frame: 8-bit words on half the lanes, HDR exposure from the pins
    wr(isr_pkg::A_BIT_MODE, {14'h0000, isr_pkg::BM_8});
    wr(isr_pkg::A_LANE_MODE, 16'h0001);
    wr(isr_pkg::A_CTRL, 16'h0003);
    wd = 8;
    lm = 1;
    nw = 0;
    frame_req = 1'b1;
    repeat (125) @(negedge clock_i);
    frame_req = 1'b0;
    // Even columns get the short pulse, odd columns the long one
    texp1 = 1'b1;
    texp2 = 1'b1;
    repeat (10) @(negedge clock_i);
    texp1 = 1'b0;
    repeat (20) @(negedge clock_i);
    texp2 = 1'b0;
    for (int i = 0; i < 20000 && nw < 512; i++)
      @(negedge clock_i);
    repeat (2000) @(negedge clock_i);
    chk16(16'(nw), 16'h0200);
    chk16(16'(nr), 16'h0004);
    chk16(16'(n_even), 16'h001a);
    chk16(16'(n_odd), 16'h002e);
    results();
  end
endmodule
